// [ssp_pkg.sv]
/*
 * ssp_pkg: constants and carrier types of the sensor serial port.
 * Assumes one core clock at 125 MHz and a host-made serial clock.
 */
package ssp_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [6:0] ADDR_DELTA_X = 7'h03;
	localparam logic [6:0] ADDR_DELTA_Y = 7'h04;
	localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
	localparam logic [6:0] ADDR_EXPO_UPPER = 7'h06;
	localparam logic [6:0] ADDR_EXPO_LOWER = 7'h07;
	localparam logic [6:0] ADDR_PEAK_PIXEL = 7'h08;
	localparam logic [6:0] ADDR_PIXEL_SUM = 7'h09;
	localparam logic [6:0] ADDR_DEVICE_CONTROL = 7'h0d;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h3a;
	localparam logic [6:0] ADDR_MOTION_BURST = 7'h63;
	localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;
	localparam logic [7:0] DEVICE_CONTROL_RST = 8'h00;
	localparam int CTRL_PWRDN_BIT = 1;
	localparam int BURST_LEN = 7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CORE_CLK_MHZ = 125;
	localparam int BURST_EXIT_NS = 250;
	localparam int BURST_EXIT_CYC = (BURST_EXIT_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int ADDR_TO_DATA_US = 4;
	localparam int WRITE_WRITE_US = 30;
	localparam int WRITE_READ_US = 20;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] delta_x;
		logic [7:0] delta_y;
		logic [7:0] surface_quality;
		logic [7:0] expo_upper;
		logic [7:0] expo_lower;
		logic [7:0] peak_pixel;
		logic [7:0] pixel_sum;
	} ssp_motion_t;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} ssp_write_t;

endpackage : ssp_pkg

// [ssp_sync.sv]
/*
 * ssp_sync: two flip-flop level synchroniser.
 * Assumes the input is a level from another clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module ssp_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : ssp_sync
`default_nettype wire

// [ssp_port.sv]
/*
 * ssp_port: three-wire serial slave of the motion sensor, with burst,
 * soft reset and power down. Assumes the host makes sclk, which runs
 * only inside frames, and that motion values arrive on core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module ssp_port (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic port_select_low,
	input wire logic hard_reset_low,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	input wire ssp_pkg::ssp_motion_t motion_in,
	output var ssp_pkg::ssp_motion_t motion_rd,
	output logic illum_led_drive,
	output logic illum_led_oe_n,
	output logic power_down,
	output logic [7:0] device_control
);
	import ssp_pkg::*;

	// ----------------------------------------
	// core-side reset and select sync
	// ----------------------------------------
	logic hrst_sync, cs_sync, chip_rst_n;
	logic soft_rst_r;
	ssp_sync u_hrst (.clk(core_clk), .rst_n(arst_n), .d(hard_reset_low), .q(hrst_sync));
	ssp_sync u_cs (.clk(core_clk), .rst_n(arst_n), .d(port_select_low), .q(cs_sync));

	// pin asserts at once, release waits for the synced copy
	assign chip_rst_n = arst_n & hard_reset_low & hrst_sync & ~soft_rst_r;

	// link side: select high resets the port logic
	logic link_rst_n;
	assign link_rst_n = chip_rst_n & ~port_select_low;

	// ----------------------------------------
	// burst snapshot handshake, link to core
	// ----------------------------------------
	logic snap_tgl_r; // link domain
	logic snap_s1_r, snap_s2_r, snap_s3_r;
	ssp_motion_t snap_r;

	// toggle crosses to core; snapshot taken there
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			snap_s1_r <= 1'b0;
			snap_s2_r <= 1'b0;
			snap_s3_r <= 1'b0;
		end else begin
			snap_s1_r <= snap_tgl_r;
			snap_s2_r <= snap_s1_r;
			snap_s3_r <= snap_s2_r;
		end
	end

	// capture on the rise only; select high clears the flag, and that
	// fall must not overwrite the set the host has just read
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			snap_r <= '0;
		end else if (snap_s2_r && !snap_s3_r) begin
			snap_r <= motion_in;
		end
	end

	// ----------------------------------------
	// write hand-over, link to core
	// ----------------------------------------
	logic wr_tgl_r;
	logic [6:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic wr_s1_r, wr_s2_r, wr_s3_r;
	logic [7:0] ctrl_r;

	// event synchroniser; addr and data are stable long before it lands
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			wr_s1_r <= 1'b0;
			wr_s2_r <= 1'b0;
			wr_s3_r <= 1'b0;
		end else begin
			wr_s1_r <= wr_tgl_r;
			wr_s2_r <= wr_s1_r;
			wr_s3_r <= wr_s2_r;
		end
	end

	logic wr_fire;
	assign wr_fire = wr_s2_r && !wr_s3_r; // rise only: select high clears the flag

	// control register write
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			ctrl_r <= DEVICE_CONTROL_RST;
		end else if (wr_fire && wr_addr_r == ADDR_DEVICE_CONTROL) begin
			ctrl_r <= wr_data_r;
		end
	end

	// soft reset pulse; arst only, so it clears itself next edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_fire && wr_addr_r == ADDR_SOFT_RESET
				&& wr_data_r == SOFT_RESET_KEY && hrst_sync;
		end
	end

	assign device_control = ctrl_r;
	assign power_down = ctrl_r[CTRL_PWRDN_BIT];
	assign motion_rd = snap_r;

	// led pulsing is outside this block; hold released in reset
	assign illum_led_drive = 1'b0;
	assign illum_led_oe_n = ~(chip_rst_n & hrst_sync & ~power_down);

	// ----------------------------------------
	// burst exit timer, core domain
	// ----------------------------------------
	logic burst_lock_r; // link domain: a burst was started
	logic lock_s1_r, lock_s2_r;
	logic [7:0] exit_cnt_r;
	logic port_ok_r;

	// lock seen in core; select must stay high the exit time
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			lock_s1_r <= 1'b0;
			lock_s2_r <= 1'b0;
		end else begin
			lock_s1_r <= burst_lock_r;
			lock_s2_r <= lock_s1_r;
		end
	end

	// counts select-high time after a burst; port reopens when done
	always_ff @(posedge core_clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			exit_cnt_r <= '0;
			port_ok_r <= 1'b1;
		end else if (lock_s2_r) begin
			port_ok_r <= 1'b0;
			exit_cnt_r <= '0;
		end else if (!port_ok_r) begin
			if (!cs_sync) begin
				exit_cnt_r <= '0; // select fell too soon: restart
			end else if (exit_cnt_r >= 8'(BURST_EXIT_CYC - 1)) begin
				port_ok_r <= 1'b1;
			end else begin
				exit_cnt_r <= exit_cnt_r + 8'd1;
			end
		end
	end

	// port_ok crosses into the link domain as a level
	logic ok_l1_r, ok_l2_r;
	logic pd_l1_r, pd_l2_r;
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ok_l1_r <= 1'b1;
			ok_l2_r <= 1'b1;
			pd_l1_r <= 1'b0;
			pd_l2_r <= 1'b0;
		end else begin
			ok_l1_r <= port_ok_r;
			ok_l2_r <= ok_l1_r;
			pd_l1_r <= power_down;
			pd_l2_r <= pd_l1_r;
		end
	end

	// ----------------------------------------
	// link: receive shift on rising sclk
	// ----------------------------------------
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic byte_idx_r; // 0 address byte, 1 data phase
	logic is_write_r;
	logic [6:0] addr_r;
	logic in_burst_r;
	logic [2:0] burst_idx_r;
	logic read_phase_r;
	logic blocked;

	// sclk stops between frames, so the ok flops leave reset open and a
	// locked port stalls from the third bit on
	assign blocked = (ok_l2_r == 1'b0 && bit_cnt_r != 3'd0) || pd_l2_r;

	// shift msb first; byte boundaries every eight rising edges
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_r <= '0;
			shift_r <= '0;
			byte_idx_r <= 1'b0;
			is_write_r <= 1'b0;
			addr_r <= '0;
			read_phase_r <= 1'b0;
			in_burst_r <= 1'b0;
			burst_lock_r <= 1'b0;
			snap_tgl_r <= 1'b0;
			wr_tgl_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			burst_idx_r <= '0;
		end else if (!blocked || byte_idx_r) begin
			bit_cnt_r <= bit_cnt_r + 3'd1;
			shift_r <= {shift_r[5:0], sdio_in};
			if (bit_cnt_r == 3'd7 && !byte_idx_r) begin
				byte_idx_r <= 1'b1;
				is_write_r <= shift_r[6];
				addr_r <= {shift_r[5:0], sdio_in};
				if (!shift_r[6]) begin
					read_phase_r <= 1'b1;
					if ({shift_r[5:0], sdio_in} == ADDR_MOTION_BURST) begin
						in_burst_r <= 1'b1;
						burst_lock_r <= 1'b1;
						snap_tgl_r <= ~snap_tgl_r;
					end
				end
			end else if (bit_cnt_r == 3'd7) begin
				if (is_write_r && !read_phase_r) begin
					wr_addr_r <= addr_r;
					wr_data_r <= {shift_r, sdio_in};
					wr_tgl_r <= ~wr_tgl_r;
					read_phase_r <= 1'b0;
				end
				if (in_burst_r && burst_idx_r != 3'(BURST_LEN - 1)) begin
					burst_idx_r <= burst_idx_r + 3'd1;
				end else begin
					read_phase_r <= 1'b0; // single read ends after one byte
					in_burst_r <= in_burst_r;
				end
			end
		end
	end

	// ----------------------------------------
	// link: read byte selection
	// ----------------------------------------
	function automatic logic [7:0] burst_byte(input ssp_motion_t m, input logic [2:0] i);
		case (i)
			3'd0: burst_byte = m.delta_x;
			3'd1: burst_byte = m.delta_y;
			3'd2: burst_byte = m.surface_quality;
			3'd3: burst_byte = m.expo_upper;
			3'd4: burst_byte = m.expo_lower;
			3'd5: burst_byte = m.peak_pixel;
			default: burst_byte = m.pixel_sum;
		endcase
	endfunction

	// plain reads: the control register or a motion value by address
	logic [7:0] rd_byte;
	always_comb begin
		if (in_burst_r) begin
			rd_byte = burst_byte(snap_r, burst_idx_r);
		end else if (addr_r == ADDR_DEVICE_CONTROL) begin
			rd_byte = ctrl_r;
		end else if (addr_r >= ADDR_DELTA_X && addr_r <= ADDR_PIXEL_SUM) begin
			rd_byte = burst_byte(motion_in, 3'(addr_r - ADDR_DELTA_X));
		end else begin
			rd_byte = 8'h00;
		end
	end

	// ----------------------------------------
	// link: drive on falling sclk
	// ----------------------------------------
	// snap_r and ctrl_r are quiet for the address-to-data delay
	logic [7:0] out_sh_r;
	logic drive_r;
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_sh_r <= '0;
			drive_r <= 1'b0;
		end else if (read_phase_r && byte_idx_r) begin
			drive_r <= 1'b1;
			if (bit_cnt_r == 3'd0) begin
				out_sh_r <= rd_byte;
			end else begin
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end else begin
			drive_r <= 1'b0;
		end
	end

	assign sdio_out = out_sh_r[7];
	// release whenever select is high or chip is held
	assign sdio_oe_n = ~(drive_r & ~port_select_low & chip_rst_n);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_soft_write;
		wr_fire && wr_addr_r == ADDR_SOFT_RESET && wr_data_r == SOFT_RESET_KEY;
	endsequence

	property p_soft_reset;
		@(posedge core_clk) disable iff (!arst_n || !hard_reset_low)
		s_soft_write |=> soft_rst_r;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

	property p_select_release;
		@(posedge core_clk) disable iff (!arst_n)
		port_select_low |-> sdio_oe_n;
	endproperty
	a_select_release: assert property (p_select_release) else $error("drive with select high");

	property p_lock_burst;
		@(posedge core_clk) disable iff (!chip_rst_n)
		lock_s2_r |=> !port_ok_r;
	endproperty
	a_lock_burst: assert property (p_lock_burst) else $error("port open during burst");

	property p_exit_time;
		@(posedge core_clk) disable iff (!chip_rst_n)
		$rose(port_ok_r) |-> exit_cnt_r == 8'(BURST_EXIT_CYC - 1);
	endproperty
	a_exit_time: assert property (p_exit_time) else $error("burst exit too early");

	property p_pwrdn;
		@(posedge core_clk) disable iff (!chip_rst_n)
		wr_fire && wr_addr_r == ADDR_DEVICE_CONTROL |=> power_down == wr_data_r[CTRL_PWRDN_BIT];
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("power down bit wrong");

	property p_snapshot;
		@(posedge core_clk) disable iff (!chip_rst_n)
		snap_s2_r && !snap_s3_r |=> snap_r == $past(motion_in);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("burst set not captured");

	property p_led_reset;
		@(posedge core_clk) !hard_reset_low |-> illum_led_oe_n;
	endproperty
	a_led_reset: assert property (p_led_reset) else $error("led driven in reset");

	property p_drive_read;
		@(negedge sclk) disable iff (!link_rst_n)
		drive_r |-> read_phase_r || $past(read_phase_r);
	endproperty
	a_drive_read: assert property (p_drive_read) else $error("drive outside read");

endmodule : ssp_port
`default_nettype wire

// [ssp_host_model.sv]
/*
 * ssp_host_model: host side of the three-wire port; makes sclk, select
 * and host data. Assumes the bench resolves the shared data wire.
 */
`timescale 1ns/100ps
`default_nettype none
module ssp_host_model (
	output logic sclk,
	output logic sel_n,
	output logic hbit,
	output logic hoe,
	input wire logic sdio
);
	logic [7:0] rd_byte;
	event got;
	// ----------------------------------------
	// idle: clock parked high, nothing selected
	// ----------------------------------------
	initial begin
		sclk = 1'b1;
		sel_n = 1'b1;
		hbit = 1'b0;
		hoe = 1'b0;
	end
	// only the host ever opens a frame, one per transaction
	task open;
		sel_n = 1'b0;
		#200;
	endtask : open
	// msb first, changed while clock low, n bits
	task send(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sclk = 1'b0;
			hoe = 1'b1;
			hbit = b[i];
			#6;
			sclk = 1'b1;
			#6;
		end
		hoe = 1'b0;
		hbit = ~hbit; // released wire must not keep the last bit
	endtask : send
	// one byte, no gap between bytes of a burst
	task recv;
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			#6;
			sclk = 1'b1;
			rd_byte[i] = sdio;
			#6;
		end
		->got;
	endtask : recv
	// select rise ends or aborts the frame; hold covers exit and gaps
	task close(input int hold);
		#120;
		sel_n = 1'b1;
		#(hold);
	endtask : close
endmodule : ssp_host_model
`default_nettype wire

// [test_sensor_serial_port_burst.sv]
/*
 * test_sensor_serial_port_burst: self-checking bench of ssp_port.
 * Assumes ssp_pkg and ssp_host_model; sclk runs only inside frames.
 */
`timescale 1ns/100ps
`default_nettype none
module test_sensor_serial_port_burst;
	import ssp_pkg::*;
	logic core_clk, arst_n, hard_reset_low, sdio_out, sdio_oe_n;
	logic illum_led_drive, illum_led_oe_n, power_down, idle_pat, sdio;
	logic sclk, sel_n, hbit, hoe;
	logic [7:0] device_control, d;
	logic [63:0] r;
	ssp_motion_t motion_in, motion_rd, snap;
	int bad_count, check_count, seed;
	logic [7:0] exp_q[$];
	// ----------------------------------------
	// clock, shared wire, instances
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// undriven wire toggles so a stale bit never passes
	always @(posedge core_clk) idle_pat <= (idle_pat === 1'b0);
	assign sdio = !sdio_oe_n ? sdio_out : (hoe ? hbit : idle_pat);
	ssp_port dut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk),
		.port_select_low(sel_n), .hard_reset_low(hard_reset_low),
		.sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.motion_in(motion_in), .motion_rd(motion_rd),
		.illum_led_drive(illum_led_drive), .illum_led_oe_n(illum_led_oe_n),
		.power_down(power_down), .device_control(device_control));
	ssp_host_model host (.sclk(sclk), .sel_n(sel_n), .hbit(hbit), .hoe(hoe),
		.sdio(sdio));
	// ----------------------------------------
	// compares and closing
	// ----------------------------------------
	task cmp_port(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_port
	task cmp_byte(input logic [7:0] got);
		logic [7:0] e;
		e = (exp_q.size() == 0) ? 8'hzz : exp_q.pop_front();
		cmp_port(got, e);
	endtask : cmp_byte
	// oldest note against each byte the host takes in
	always @(host.got) cmp_byte(host.rd_byte);
	task conclude;
		if (exp_q.size() != 0) bad_count++;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// run is near 270 us; twice that means a hang
	initial begin
		#(18 * WRITE_WRITE_US * 1000);
		bad_count++;
		conclude;
	end
	// ----------------------------------------
	// transactions
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	// wait covers both write gaps before the next command
	task wr(input logic [6:0] a, input logic [7:0] v);
		tick(1);
		host.open();
		host.send({1'b1, a}, 8);
		host.send(v, 8);
		host.close(0);
		tick(WRITE_WRITE_US * CORE_CLK_MHZ);
	endtask : wr
	task rd(input logic [6:0] a, input int n);
		tick(1);
		host.open();
		host.send({1'b0, a}, 8);
		cmp_port({7'h00, sdio_oe_n}, 8'h01);
		tick(12);
		if (a == ADDR_MOTION_BURST) motion_in = ~motion_in; // late change
		#(ADDR_TO_DATA_US * 1000);
		repeat (n) host.recv();
		cmp_port({7'h00, sdio_oe_n}, 8'h00);
		host.close(0);
		#1;
		cmp_port({7'h00, sdio_oe_n}, 8'h01);
		#600;
	endtask : rd
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h7653593b;
		bad_count = 0;
		check_count = 0;
		arst_n = 1'b0;
		hard_reset_low = 1'b0;
		r = {$random(seed), $random(seed)};
		motion_in = r[55:0];
		repeat (8) @(posedge core_clk);
		#1;
		cmp_port(device_control, DEVICE_CONTROL_RST);
		cmp_port({5'h00, illum_led_drive, sdio_oe_n, illum_led_oe_n}, 8'h03);
		arst_n = 1'b1;
		hard_reset_low = 1'b1;
		tick(3);
		cmp_port({7'h00, sdio_oe_n}, 8'h01);
		// random control values, power-down bit kept clear
		for (int k = 0; k < 3; k++) begin
			d = $random(seed) & 8'hfd;
			wr(ADDR_DEVICE_CONTROL, d);
			cmp_port(device_control, d);
			exp_q.push_back(d);
			rd(ADDR_DEVICE_CONTROL, 1);
		end
		snap = motion_in;
		exp_q.push_back(snap.delta_x);
		rd(ADDR_DELTA_X, 1);
		// full burst; live values change after the address byte
		snap = motion_in;
		for (int i = 0; i < BURST_LEN; i++) exp_q.push_back(snap[55 - 8 * i -: 8]);
		rd(ADDR_MOTION_BURST, BURST_LEN);
		cmp_port(motion_rd.pixel_sum, snap.pixel_sum);
		snap = motion_in;
		exp_q.push_back(snap.delta_x);
		rd(ADDR_MOTION_BURST, 1);
		// burst frame is served; the write opened 100 ns after it is too soon and must be ignored
		tick(1);
		host.open();
		host.send({1'b0, ADDR_MOTION_BURST}, 8);
		exp_q.push_back(motion_in.delta_x);
		#(ADDR_TO_DATA_US * 1000);
		host.recv();
		host.close(100);
		wr(ADDR_DEVICE_CONTROL, d ^ 8'h01);
		cmp_port(device_control, d);
		exp_q.push_back(d);
		rd(ADDR_DEVICE_CONTROL, 1);
		// write cut short by select after 12 bits
		tick(1);
		host.open();
		host.send({1'b1, ADDR_DEVICE_CONTROL}, 8);
		host.send(8'hff, 4);
		host.close(600);
		tick(WRITE_WRITE_US * CORE_CLK_MHZ);
		cmp_port(device_control, d);
		wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
		cmp_port(device_control, DEVICE_CONTROL_RST);
		wr(ADDR_DEVICE_CONTROL, 8'h02);
		cmp_port({7'h00, power_down}, 8'h01);
		// leave power down through the reset pin
		hard_reset_low = 1'b0;
		tick(4);
		cmp_port({device_control[6:0], illum_led_oe_n}, 8'h01);
		hard_reset_low = 1'b1;
		tick(3);
		cmp_port({7'h00, power_down}, 8'h00);
		exp_q.push_back(DEVICE_CONTROL_RST);
		rd(ADDR_DEVICE_CONTROL, 1);
		conclude;
	end
endmodule : test_sensor_serial_port_burst
`default_nettype wire
